// ### include/arcf_pkg.sv
/*
 * Shared constants, types and helpers of the array routing and clock fabric.
 * Assumes a single clock domain and configuration loaded before normal operation.
 */
// Summary of operation
// - Repeaters cut every local and express bus into eight-cell segments, forming sectors.
// - Two north-south buses per column, two east-west per row, reaching every sector cell.
// - A cell turns a signal between bus-one pair or bus-two pair via two pass gates.
// - Every local bus has a paired express bus that no cell touches directly.
// - Each repeater serves one local/express pair with twenty-one symmetric functions.
// - Functions include isolate, local join, express join and local/express transfer.
// - Each repeater connection regenerates the signal and drives one direction only.
// - Bus-two repeaters also offer a bidirectional local link for long tristate buses.
// - A cell reads a bus by enabling its pass gate and selecting it in the input mux.
// - A cell writes a bus with both gates on; drive is constant or B-input tristated.
// - Each local bus at a cell takes part in one operation only.
// - Each column clock select picks global pin, express bus, head cell or constant one.
// - Columns clock independently; constant one stops clocking in that column.
// - The global clock pin also feeds the two upper corner cell inputs.
// - The global clock reaches any subset of columns with equal delay.
// - Global-clocked flip-flops update on its rising edge; configuration never affects it.
package arcf_pkg;
	// ----------------------------------------------------------------
	// Array geometry
	// ----------------------------------------------------------------
	localparam int COLS = 16;
	localparam int ROWS = 16;
	localparam int SECT = 8;
	localparam int NSEG = 2;
	localparam int CELLS = COLS * ROWS;
	localparam int NS_LINES = 2 * COLS;
	localparam int LINES = NS_LINES + 2 * ROWS;
	localparam int NBUS = 4;
	localparam int FN_W = 5;

	// Bus index at a cell: north-south one and two, east-west one and two.
	localparam int BUS_NS1 = 0;
	localparam int BUS_EW1 = 2;

	// ----------------------------------------------------------------
	// Codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ARCF_OP_NONE = 2'h0,
		ARCF_OP_READ = 2'h1,
		ARCF_OP_WRITE = 2'h2,
		ARCF_OP_TURN = 2'h3
	} arcf_op_t;

	localparam logic [1:0] RD_NONE = 2'h0;
	localparam logic [1:0] RD_NS = 2'h1;
	localparam logic [1:0] RD_EW = 2'h2;

	localparam logic [1:0] CK_GLOBAL = 2'h0;
	localparam logic [1:0] CK_EXPRESS = 2'h1;
	localparam logic [1:0] CK_HEAD = 2'h2;
	localparam logic [1:0] CK_ONE = 2'h3;

	// Repeater source codes; A is the lower segment side, B the upper.
	localparam logic [2:0] SRC_N = 3'h0;
	localparam logic [2:0] SRC_AL = 3'h1;
	localparam logic [2:0] SRC_AE = 3'h2;
	localparam logic [2:0] SRC_BL = 3'h3;
	localparam logic [2:0] SRC_BE = 3'h4;

	localparam logic [FN_W-1:0] FN_ISOLATE = 5'h00;

	// Per-cell configuration: op per bus, turn direction, read select, tristate mode.
	typedef struct packed {
		arcf_op_t [NBUS-1:0] op;
		logic [NBUS-1:0] turn_in;
		logic [1:0] rd_sel;
		logic drv_b;
	} arcf_cell_cfg_t;

	localparam arcf_cell_cfg_t CELL_CFG_RST = '0;

	// Cell index of position p along line l.
	function automatic int line_cell(input int l, input int p);
		if (l < NS_LINES) begin
			return p * COLS + l / 2;
		end
		return ((l - NS_LINES) / 2) * COLS + p;
	endfunction

	// Bus index that line l occupies at each of its cells.
	function automatic int line_bus(input int l);
		return (l < NS_LINES) ? (BUS_NS1 + l % 2) : (BUS_EW1 + l % 2);
	endfunction
endpackage

// ### include/arcf_seg_if.sv
/*
 * Segment pair carrier between the fabric and one repeater.
 * Assumes A is the lower segment and B the upper one of a local/express pair.
 */
`timescale 1ns/10ps
interface arcf_seg_if;
	logic a_loc;
	logic a_exp;
	logic b_loc;
	logic b_exp;
	logic a_cell;
	logic b_cell;
	// Drive order: A local, A express, B local, B express.
	logic [3:0] drv_en;
	logic [3:0] drv_val;

	modport rep (
		input a_loc, input a_exp, input b_loc, input b_exp,
		input a_cell, input b_cell,
		output drv_en, output drv_val
	);
	modport fab (
		output a_loc, output a_exp, output b_loc, output b_exp,
		output a_cell, output b_cell,
		input drv_en, input drv_val
	);
endinterface

// ### hw/arcf_repeater.sv
/*
 * One programmable repeater joining two segments of a local/express pair.
 * Assumes a static function code and segment values free of repeater loops.
 */
`timescale 1ns/10ps
module arcf_repeater (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [arcf_pkg::FN_W-1:0] fn,
	input wire logic bidir,
	arcf_seg_if.rep seg
);
	// Route table: sources for {B exp, B loc, A exp, A loc}.
	// Twenty-one functions
	function automatic logic [11:0] fn_route(input logic [4:0] f);
		case (f)
			5'h01: return {arcf_pkg::SRC_N, arcf_pkg::SRC_AL, arcf_pkg::SRC_N, arcf_pkg::SRC_N};
			5'h02: return {arcf_pkg::SRC_AL, arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_N};
			5'h03: return {arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_AL, arcf_pkg::SRC_N};
			5'h04: return {arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_BL};
			5'h05: return {arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_BL, arcf_pkg::SRC_N};
			5'h06: return {arcf_pkg::SRC_BL, arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_N};
			5'h07: return {arcf_pkg::SRC_AE, arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_N};
			5'h08: return {arcf_pkg::SRC_N, arcf_pkg::SRC_AE, arcf_pkg::SRC_N, arcf_pkg::SRC_N};
			5'h09: return {arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_AE};
			5'h0a: return {arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_BE, arcf_pkg::SRC_N};
			5'h0b: return {arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_BE};
			5'h0c: return {arcf_pkg::SRC_N, arcf_pkg::SRC_BE, arcf_pkg::SRC_N, arcf_pkg::SRC_N};
			5'h0d: return {arcf_pkg::SRC_AE, arcf_pkg::SRC_AL, arcf_pkg::SRC_N, arcf_pkg::SRC_N};
			5'h0e: return {arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_BE, arcf_pkg::SRC_BL};
			5'h0f: return {arcf_pkg::SRC_N, arcf_pkg::SRC_AL, arcf_pkg::SRC_BE, arcf_pkg::SRC_N};
			5'h10: return {arcf_pkg::SRC_AE, arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_BL};
			5'h11: return {arcf_pkg::SRC_AL, arcf_pkg::SRC_AE, arcf_pkg::SRC_N, arcf_pkg::SRC_N};
			5'h12: return {arcf_pkg::SRC_N, arcf_pkg::SRC_N, arcf_pkg::SRC_BL, arcf_pkg::SRC_BE};
			5'h13: return {arcf_pkg::SRC_AL, arcf_pkg::SRC_N, arcf_pkg::SRC_BL, arcf_pkg::SRC_N};
			5'h14: return {arcf_pkg::SRC_N, arcf_pkg::SRC_AE, arcf_pkg::SRC_N, arcf_pkg::SRC_BE};
			default: return 12'h000;
		endcase
	endfunction

	wire [11:0] route = fn_route(fn);
	wire [3:0] src_val = {seg.b_exp, seg.b_loc, seg.a_exp, seg.a_loc};
	wire [3:0] pick_en;
	wire [3:0] pick_val;

	// Each destination takes at most its one selected source.
	// Isolate, join, transfer
	genvar d;
	generate
		for (d = 0; d < 4; d++) begin : g_dst
			wire [2:0] s = route[3*d +: 3];
			assign pick_en[d] = (s != arcf_pkg::SRC_N);
			assign pick_val[d] = pick_en[d] & src_val[2'(s - 3'h1)];
		end
	endgenerate

	// Bidirectional link follows whichever side has a cell writing.
	// Bidirectional local link
	wire bd_to_a = bidir & seg.b_cell & ~seg.a_cell;
	wire bd_to_b = bidir & seg.a_cell & ~seg.b_cell;
	wire [3:0] en_d = pick_en | {1'b0, bd_to_b, 1'b0, bd_to_a};
	wire [3:0] val_d = pick_val | {1'b0, bd_to_b & seg.a_loc, 1'b0, bd_to_a & seg.b_loc};

	// Regenerating stage; drives only toward the chosen destination.
	// Regenerated one-way drive
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			seg.drv_en <= 4'h0;
			seg.drv_val <= 4'h0;
		end else begin
			seg.drv_en <= en_d;
			seg.drv_val <= val_d & en_d;
		end
	end
endmodule

// ### hw/arcf_cell_port.sv
/*
 * Local bus access of one logic cell: read mux, write drivers and turns.
 * Assumes its configuration is static and gives each bus one operation.
 */
`timescale 1ns/10ps
module arcf_cell_port (
	input wire logic clk_sys,
	input wire logic rst,
	input wire arcf_pkg::arcf_cell_cfg_t cfg,
	input wire logic [arcf_pkg::NBUS-1:0] bus_in,
	input wire logic wr_data,
	input wire logic b_in,
	output logic [arcf_pkg::NBUS-1:0] bus_en,
	output logic [arcf_pkg::NBUS-1:0] bus_val,
	output logic rd_val
);
	logic [arcf_pkg::NBUS-1:0] turn_q;
	wire [arcf_pkg::NBUS-1:0] is_rd;
	wire [arcf_pkg::NBUS-1:0] wr_en;
	wire [arcf_pkg::NBUS-1:0] turn_on;

	// Per-bus decode; the op field admits one operation per bus only.
	// One operation per bus
	genvar k;
	generate
		for (k = 0; k < arcf_pkg::NBUS; k++) begin : g_bus
			assign is_rd[k] = (cfg.op[k] == arcf_pkg::ARCF_OP_READ);
			assign wr_en[k] = (cfg.op[k] == arcf_pkg::ARCF_OP_WRITE) & (~cfg.drv_b | b_in);
			assign turn_on[k] = (cfg.op[k] == arcf_pkg::ARCF_OP_TURN) &
				(cfg.op[k ^ 2] == arcf_pkg::ARCF_OP_TURN) & cfg.turn_in[k];
			assign bus_en[k] = wr_en[k] | turn_on[k];
			assign bus_val[k] = wr_en[k] ? wr_data : (turn_on[k] & turn_q[k]);
		end
	endgenerate

	// Turned value is regenerated from the partner bus one clock later.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			turn_q <= 4'h0;
		end else begin
			turn_q <= {bus_in[1:0], bus_in[3:2]};
		end
	end

	// Three-input select: nothing, a read-enabled north-south or east-west bus.
	// Read select
	wire ns_rd = |(bus_in[1:0] & is_rd[1:0]);
	wire ew_rd = |(bus_in[3:2] & is_rd[3:2]);
	assign rd_val = (cfg.rd_sel == arcf_pkg::RD_NS) ? ns_rd :
		(cfg.rd_sel == arcf_pkg::RD_EW) ? ew_rd : 1'b0;
endmodule

// ### hw/arcf_fabric.sv
/*
 * Routing fabric of the cell array: segmented local and express buses,
 * repeaters, cell bus access and per-column clock selection.
 * Assumes all inputs are synchronous to clk_sys and that configuration is
 * loaded with cfg_load before the array is used.
 */
`timescale 1ns/10ps
module arcf_fabric (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cfg_load,
	input wire arcf_pkg::arcf_cell_cfg_t [arcf_pkg::CELLS-1:0] cfg_cell,
	input wire logic [arcf_pkg::LINES-1:0][arcf_pkg::FN_W-1:0] cfg_rep_fn,
	input wire logic [arcf_pkg::LINES-1:0] cfg_rep_bidir,
	input wire logic [arcf_pkg::COLS-1:0][1:0] cfg_col_clk,
	input wire logic [arcf_pkg::CELLS-1:0] cell_wr_data,
	input wire logic [arcf_pkg::CELLS-1:0] cell_b_in,
	input wire logic [arcf_pkg::COLS-1:0] head_a_out,
	input wire logic global_clock_pin,
	input wire logic [arcf_pkg::LINES-1:0] exp_edge_in,
	output logic [arcf_pkg::CELLS-1:0] cell_rd_q,
	output logic [arcf_pkg::LINES-1:0] exp_edge_out_q,
	output logic [arcf_pkg::COLS-1:0] col_clk_q,
	output logic [arcf_pkg::COLS-1:0] col_rise_q,
	output logic corner_left_clock_input_q,
	output logic corner_right_clock_input_q
);
	// ----------------------------------------------------------------
	// Static configuration store
	// ----------------------------------------------------------------
	arcf_pkg::arcf_cell_cfg_t [arcf_pkg::CELLS-1:0] cell_cfg_q;
	logic [arcf_pkg::LINES-1:0][arcf_pkg::FN_W-1:0] rep_fn_q;
	logic [arcf_pkg::LINES-1:0] rep_bidir_q;
	logic [arcf_pkg::COLS-1:0][1:0] col_sel_q;

	// Configuration is captured only on a load strobe and held otherwise.
	// Static configuration bits
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cell_cfg_q <= {arcf_pkg::CELLS{arcf_pkg::CELL_CFG_RST}};
			rep_fn_q <= {arcf_pkg::LINES{arcf_pkg::FN_ISOLATE}};
			rep_bidir_q <= '0;
			col_sel_q <= {arcf_pkg::COLS{arcf_pkg::CK_ONE}};
		end else if (cfg_load) begin
			cell_cfg_q <= cfg_cell;
			rep_fn_q <= cfg_rep_fn;
			rep_bidir_q <= cfg_rep_bidir;
			col_sel_q <= cfg_col_clk;
		end
	end

	// ----------------------------------------------------------------
	// Cell bus access
	// ----------------------------------------------------------------
	wire [arcf_pkg::NBUS-1:0] cell_bus [arcf_pkg::CELLS];
	wire [arcf_pkg::NBUS-1:0] cell_en [arcf_pkg::CELLS];
	wire [arcf_pkg::NBUS-1:0] cell_val [arcf_pkg::CELLS];
	wire [arcf_pkg::CELLS-1:0] cell_rd;

	// One access port per cell on its two north-south and two east-west buses.
	// Four local buses per cell
	genvar c;
	generate
		for (c = 0; c < arcf_pkg::CELLS; c++) begin : g_cell
			arcf_cell_port u_port (
				.clk_sys(clk_sys),
				.rst(rst),
				.cfg(cell_cfg_q[c]),
				.bus_in(cell_bus[c]),
				.wr_data(cell_wr_data[c]),
				.b_in(cell_b_in[c]),
				.bus_en(cell_en[c]),
				.bus_val(cell_val[c]),
				.rd_val(cell_rd[c])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Bus lines: two segments of eight cells with a repeater between
	// ----------------------------------------------------------------
	wire [arcf_pkg::NSEG-1:0] line_loc [arcf_pkg::LINES];
	wire [arcf_pkg::NSEG-1:0] line_exp [arcf_pkg::LINES];

	genvar l;
	genvar p;
	generate
		for (l = 0; l < arcf_pkg::LINES; l++) begin : g_line
			localparam int B = arcf_pkg::line_bus(l);
			wire [arcf_pkg::SECT-1:0] drv0;
			wire [arcf_pkg::SECT-1:0] drv1;
			wire [arcf_pkg::SECT-1:0] any0;
			wire [arcf_pkg::SECT-1:0] any1;
			arcf_seg_if seg();

			// Cell drivers are collected per eight-cell segment.
			// Eight-cell segments
			for (p = 0; p < arcf_pkg::SECT; p++) begin : g_pos
				localparam int C0 = arcf_pkg::line_cell(l, p);
				localparam int C1 = arcf_pkg::line_cell(l, p + arcf_pkg::SECT);
				assign drv0[p] = cell_en[C0][B] & cell_val[C0][B];
				assign drv1[p] = cell_en[C1][B] & cell_val[C1][B];
				assign any0[p] = cell_en[C0][B];
				assign any1[p] = cell_en[C1][B];
				assign cell_bus[C0][B] = line_loc[l][0];
				assign cell_bus[C1][B] = line_loc[l][1];
			end

			// Local segment level: cell writers plus the repeater's drive.
			assign line_loc[l][0] = (|drv0) | (seg.drv_en[0] & seg.drv_val[0]);
			assign line_loc[l][1] = (|drv1) | (seg.drv_en[2] & seg.drv_val[2]);

			// Express segments see only the edge and the repeater, never a cell.
			// Express bus pairing
			assign line_exp[l][0] = exp_edge_in[l] | (seg.drv_en[1] & seg.drv_val[1]);
			assign line_exp[l][1] = seg.drv_en[3] & seg.drv_val[3];

			assign seg.a_loc = line_loc[l][0];
			assign seg.b_loc = line_loc[l][1];
			assign seg.a_exp = line_exp[l][0];
			assign seg.b_exp = line_exp[l][1];
			assign seg.a_cell = |any0;
			assign seg.b_cell = |any1;

			// The bidirectional link exists on bus-two lines only.
			// Bus-two link only
			arcf_repeater u_rep (
				.clk_sys(clk_sys),
				.rst(rst),
				.fn(rep_fn_q[l]),
				.bidir(rep_bidir_q[l] & (l % 2 == 1)),
				.seg(seg)
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Column clock selection
	// ----------------------------------------------------------------
	wire [arcf_pkg::COLS-1:0] col_sel_val;

	// Four-way select per column; express source is the column's bus-one pair.
	// Column clock select
	genvar k;
	generate
		for (k = 0; k < arcf_pkg::COLS; k++) begin : g_col
			assign col_sel_val[k] =
				(col_sel_q[k] == arcf_pkg::CK_GLOBAL) ? global_clock_pin :
				(col_sel_q[k] == arcf_pkg::CK_EXPRESS) ? line_exp[2 * k][0] :
				(col_sel_q[k] == arcf_pkg::CK_HEAD) ? head_a_out[k] : 1'b1;
		end
	endgenerate

	// Every column is registered in the same stage, so the global clock
	// reaches each selected column with equal delay.
	// Equal-delay distribution
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			col_clk_q <= '1;
		end else begin
			col_clk_q <= col_sel_val;
		end
	end

	// Rising-edge strobe per column; a constant-one column strobes at most once, on switching to it.
	// Independent columns, stop
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			col_rise_q <= '0;
		end else begin
			col_rise_q <= col_sel_val & ~col_clk_q;
		end
	end

	// Global clock pin straight to both upper corner cells, independent of config.
	// Corner clock feed
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			corner_left_clock_input_q <= 1'b0;
			corner_right_clock_input_q <= 1'b0;
		end else begin
			corner_left_clock_input_q <= global_clock_pin;
			corner_right_clock_input_q <= global_clock_pin;
		end
	end

	// ----------------------------------------------------------------
	// Registered cell reads and far-edge express outputs
	// ----------------------------------------------------------------
	wire [arcf_pkg::LINES-1:0] exp_far;

	generate
		for (l = 0; l < arcf_pkg::LINES; l++) begin : g_far
			assign exp_far[l] = line_exp[l][arcf_pkg::NSEG-1];
		end
	endgenerate

	// Values read by cells and leaving the far express segment.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cell_rd_q <= '0;
			exp_edge_out_q <= '0;
		end else begin
			cell_rd_q <= cell_rd;
			exp_edge_out_q <= exp_far;
		end
	end
endmodule

// ### bench/arcf_fabric_properties.sv
/*
 * Port checker of the routing and clock fabric, bound to its top module.
 * Assumes one clock, synchronous active-high reset and the package codes.
 */
`timescale 1ns/10ps
module arcf_fabric_properties (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cfg_load,
	input wire logic [arcf_pkg::LINES-1:0][arcf_pkg::FN_W-1:0] cfg_rep_fn,
	input wire logic [arcf_pkg::COLS-1:0][1:0] cfg_col_clk,
	input wire logic [arcf_pkg::COLS-1:0] head_a_out,
	input wire logic global_clock_pin,
	input wire logic [arcf_pkg::LINES-1:0] exp_edge_in,
	input wire logic [arcf_pkg::LINES-1:0] exp_edge_out_q,
	input wire logic [arcf_pkg::COLS-1:0] col_clk_q,
	input wire logic [arcf_pkg::COLS-1:0] col_rise_q,
	input wire logic corner_left_clock_input_q,
	input wire logic corner_right_clock_input_q
);
	// ----------------------------------------------------------------
	// Configuration shadow
	// ----------------------------------------------------------------
	logic [arcf_pkg::COLS-1:0][1:0] sel_q;
	logic [arcf_pkg::FN_W-1:0] fn0_q;

	// Mirrors the column selects and the line zero function as loaded.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sel_q <= {arcf_pkg::COLS{arcf_pkg::CK_ONE}};
			fn0_q <= arcf_pkg::FN_ISOLATE;
		end else if (cfg_load) begin
			sel_q <= cfg_col_clk;
			fn0_q <= cfg_rep_fn[0];
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_left_corner_clk: assert property (!$past(rst) |->
		corner_left_clock_input_q == $past(global_clock_pin)) else $error("left corner wrong");
	a_right_corner_clk: assert property (!$past(rst) |->
		corner_right_clock_input_q == $past(global_clock_pin)) else $error("right corner wrong");
	a_global_column_src: assert property (!$past(rst) && $past(sel_q[0]) == 2'h0 |->
		col_clk_q[0] == $past(global_clock_pin)) else $error("global column clock wrong");
	a_head_column_src: assert property (!$past(rst) && $past(sel_q[1]) == 2'h2 |->
		col_clk_q[1] == $past(head_a_out[1])) else $error("head column clock wrong");
	a_idle_column_stops: assert property (sel_q[2] == 2'h3 [*3] |->
		col_clk_q[2] && !col_rise_q[2]) else $error("idle column clocked");
	a_rise_pulse_edge: assert property (col_rise_q[0] |->
		col_clk_q[0] && !$past(col_clk_q[0])) else $error("rise pulse without edge");
	a_equal_column_skew: assert property (!$past(rst) && $past(sel_q[0]) == 2'h0 &&
		$past(sel_q[15]) == 2'h0 |-> col_clk_q[0] == col_clk_q[15]) else $error("column skew");
	a_express_join_lat: assert property (!$past(rst) && !$past(rst, 2) &&
		$past(fn0_q) == 5'h07 && $past(fn0_q, 2) == 5'h07 |->
		exp_edge_out_q[0] == $past(exp_edge_in[0], 2)) else $error("express join wrong");
	a_isolate_express: assert property ($past(fn0_q) == 5'h00 &&
		$past(fn0_q, 2) == 5'h00 |-> !exp_edge_out_q[0]) else $error("isolated segment driven");

	c_rise_seen: cover property (col_rise_q[0]);
	c_express_join: cover property (fn0_q == 5'h07 && exp_edge_out_q[0]);
	c_head_select: cover property (sel_q[1] == 2'h2 && !col_clk_q[1]);
endmodule

bind arcf_fabric arcf_fabric_properties i_props (.clk_sys(clk_sys), .rst(rst),
	.cfg_load(cfg_load), .cfg_rep_fn(cfg_rep_fn), .cfg_col_clk(cfg_col_clk),
	.head_a_out(head_a_out), .global_clock_pin(global_clock_pin),
	.exp_edge_in(exp_edge_in), .exp_edge_out_q(exp_edge_out_q), .col_clk_q(col_clk_q),
	.col_rise_q(col_rise_q), .corner_left_clock_input_q(corner_left_clock_input_q),
	.corner_right_clock_input_q(corner_right_clock_input_q));

// ### bench/arcf_cells_model.sv
/*
 * Behavioural model of the logic cells that use the buses.
 * Assumes the bench calls its tasks just after a falling clock edge.
 */
`timescale 1ns/10ps
module arcf_cells_model (
	input wire logic clk_sys,
	input wire logic rst,
	output logic [arcf_pkg::CELLS-1:0] cell_wr_data,
	output logic [arcf_pkg::CELLS-1:0] cell_b_in,
	output logic [arcf_pkg::COLS-1:0] head_a_out
);
	logic [arcf_pkg::CELLS-1:0] wr_q;
	logic [arcf_pkg::CELLS-1:0] b_q;
	logic [arcf_pkg::COLS-1:0] head_q;

	// Cells release their data and enable driving when reset.
	task automatic clear_all();
		wr_q = '0;
		b_q = '1;
		head_q = '0;
	endtask

	task automatic drive(input int idx, input logic val, input logic b_en);
		wr_q[idx] = val;
		b_q[idx] = b_en;
	endtask

	// Sets the A outputs of the column head cells.
	task automatic head_set(input logic [arcf_pkg::COLS-1:0] v);
		head_q = v;
	endtask

	// Clears the cell state at time zero and on reset, off the sampling edge.
	initial clear_all();
	always @(negedge clk_sys) begin
		if (rst) begin
			clear_all();
		end
	end

	assign cell_wr_data = wr_q;
	assign cell_b_in = b_q;
	assign head_a_out = head_q;
endmodule

// ### bench/arcf_fabric_tb.sv
/*
 * Self-checking bench of the routing and clock fabric.
 * Assumes the cell model drives cell data and the bench drives the rest.
 */
`timescale 1ns/10ps
module arcf_fabric_tb;
	logic clk_sys;
	logic rst;
	logic cfg_load;
	arcf_pkg::arcf_cell_cfg_t [arcf_pkg::CELLS-1:0] cc;
	logic [arcf_pkg::LINES-1:0][arcf_pkg::FN_W-1:0] rf;
	logic [arcf_pkg::LINES-1:0] rb;
	logic [arcf_pkg::COLS-1:0][1:0] ck;
	logic [arcf_pkg::CELLS-1:0] wr;
	logic [arcf_pkg::CELLS-1:0] bi;
	logic [arcf_pkg::COLS-1:0] head;
	logic pin;
	logic [arcf_pkg::LINES-1:0] ein;
	logic [arcf_pkg::CELLS-1:0] rd;
	logic [arcf_pkg::LINES-1:0] eout;
	logic [arcf_pkg::COLS-1:0] cclk;
	logic [arcf_pkg::COLS-1:0] crise;
	logic cl;
	logic cr;
	int err_count;
	int num_checks;
	int cyc;

	// Function codes that carry express A to express B, and express A to local B.
	localparam logic [21:0] EXP_FAR_HITS = 22'h01_2080;
	localparam logic [21:0] LOC_FAR_HITS = 22'h12_0100;

	arcf_cells_model i_cells (.clk_sys(clk_sys), .rst(rst), .cell_wr_data(wr),
		.cell_b_in(bi), .head_a_out(head));

	arcf_fabric i_dut (.clk_sys(clk_sys), .rst(rst), .cfg_load(cfg_load), .cfg_cell(cc),
		.cfg_rep_fn(rf), .cfg_rep_bidir(rb), .cfg_col_clk(ck), .cell_wr_data(wr),
		.cell_b_in(bi), .head_a_out(head), .global_clock_pin(pin), .exp_edge_in(ein),
		.cell_rd_q(rd), .exp_edge_out_q(eout), .col_clk_q(cclk), .col_rise_q(crise),
		.corner_left_clock_input_q(cl), .corner_right_clock_input_q(cr));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic got, input logic exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Pulses the load strobe for one edge; the new setup acts after it.
	task automatic load();
		cfg_load = 1'b1;
		step(1);
		cfg_load = 1'b0;
	endtask

	task automatic clear();
		cc = '0;
		rf = '0;
		rb = '0;
		ein = '0;
		i_cells.clear_all();
	endtask

	task automatic rdr(input int idx, input int bus, input logic [1:0] sel);
		cc[idx].op[bus] = arcf_pkg::ARCF_OP_READ;
		cc[idx].rd_sel = sel;
	endtask

	task automatic wrt(input int idx, input int bus, input logic drvb);
		cc[idx].op[bus] = arcf_pkg::ARCF_OP_WRITE;
		cc[idx].drv_b = drvb;
	endtask

	// Clock and hang guard.
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			$display("unexpected at %0t: timeout", $time);
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		int i;
		logic v;
		rst = 1'b1;
		cfg_load = 1'b0;
		pin = 1'b0;
		ck = {arcf_pkg::COLS{arcf_pkg::CK_ONE}};
		clear();
		step(5);
		rst = 1'b0;
		chk(rd === '0, 1'b1, "read not clear");
		chk(cclk === '1, 1'b1, "column clocks not held");
		$display("test reset done");

		// Paths at once: same segment, repeater, turn, bidir, tristate, one-way; held.
		wrt(0, 0, 1'b0);
		rdr(7 * 16, 0, arcf_pkg::RD_NS);
		rdr(8 * 16, 0, arcf_pkg::RD_NS);
		rf[0] = 5'h01;
		cc[3 * 16].op[0] = arcf_pkg::ARCF_OP_TURN;
		cc[3 * 16].op[2] = arcf_pkg::ARCF_OP_TURN;
		cc[3 * 16].turn_in[2] = 1'b1;
		rdr(3 * 16 + 5, 2, arcf_pkg::RD_EW);
		rb[1] = 1'b1;
		rb[3] = 1'b1;
		wrt(1, 1, 1'b0);
		rdr(12 * 16 + 1, 1, arcf_pkg::RD_NS);
		wrt(9 * 16, 1, 1'b0);
		rdr(2 * 16, 1, arcf_pkg::RD_NS);
		wrt(2, 0, 1'b1);
		rdr(5 * 16 + 2, 0, arcf_pkg::RD_NS);
		rf[6] = 5'h01;
		wrt(10 * 16 + 3, 0, 1'b0);
		rdr(16 + 3, 0, arcf_pkg::RD_NS);
		load();
		i_cells.drive(0, 1'b1, 1'b1);
		i_cells.drive(9 * 16, 1'b1, 1'b1);
		i_cells.drive(2, 1'b1, 1'b0);
		i_cells.drive(10 * 16 + 3, 1'b1, 1'b1);
		i_cells.drive(1, 1'b1, 1'b1);
		step(1);
		chk(rd[7 * 16], 1'b1, "same segment read");
		chk(rd[8 * 16], 1'b0, "repeater too fast");
		chk(rd[3 * 16 + 5], 1'b0, "turn too fast");
		chk(rd[5 * 16 + 2], 1'b0, "tristated write drove");
		step(1);
		chk(rd[8 * 16], 1'b1, "local join failed");
		chk(rd[3 * 16 + 5], 1'b1, "turn failed");
		chk(rd[2 * 16], 1'b1, "bidir link failed");
		chk(rd[12 * 16 + 1], 1'b1, "bidir link upward failed");
		chk(rd[16 + 3], 1'b0, "repeater drove backwards");
		i_cells.drive(2, 1'b1, 1'b1);
		i_cells.drive(0, 1'b0, 1'b1);
		step(2);
		chk(rd[5 * 16 + 2], 1'b1, "enabled write lost");
		chk(rd[8 * 16], 1'b0, "joined segment stuck");
		$display("test routing done");

		// Every function code with a pulse on express segment zero.
		clear();
		rdr(8 * 16, 0, arcf_pkg::RD_NS);
		for (i = 0; i < 22; i++) begin
			rf[0] = i[4:0];
			load();
			ein[0] = 1'b1;
			step(2);
			chk(eout[0], EXP_FAR_HITS[i], "express far side");
			chk(rd[8 * 16], LOC_FAR_HITS[i], "express to local");
			ein[0] = 1'b0;
			step(2);
		end
		$display("test repeater functions done");

		// Column clock sources toggled together.
		clear();
		ck[0] = arcf_pkg::CK_GLOBAL;
		ck[1] = arcf_pkg::CK_HEAD;
		ck[3] = arcf_pkg::CK_EXPRESS;
		ck[15] = arcf_pkg::CK_GLOBAL;
		load();
		for (i = 0; i < 6; i++) begin
			v = i[0];
			pin = v;
			i_cells.head_set({arcf_pkg::COLS{~v}});
			ein[6] = v;
			step(1);
			chk(cclk[0], v, "global column");
			chk(cclk[1], ~v, "head column");
			chk(cclk[2], 1'b1, "idle column");
			chk(cclk[3], v, "express column");
			chk(cclk[15], v, "second global column");
			chk(cl & cr, v, "corner inputs");
			chk(crise[0], v & (i > 0), "rise pulse");
		end
		$display("test clocks done");

		// Reset in mid-run returns every column to constant one.
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		pin = 1'b0;
		step(2);
		chk(cclk === '1, 1'b1, "clocks after reset");
		chk(cl | cr, 1'b0, "corners after reset");
		$display("test second reset done");
		give_verdict();
	end
endmodule
